// ### shared/cal_pkg.sv
/*
 * Constants for the sigma-delta calibration controller: register offsets,
 * field positions, reset values, modes, timing counts.
 * Assumes a 40 MHz clock and a simple strobe register port.
 */
// Functional notes
// RL1 - writing one to start bit begins calibration
// RL2 - only target differential channels; mode selects type
// RL3 - single-ended channels never get correction factors
// RL4 - result fields frozen during calibration
// RL5 - software selects single scan before calibrating
// RL6 - software keeps amp offset at zero
// RL7 - software marks one target for external
// RL8 - internal mode: offset and gain, all targets
// RL9 - internal completion raises done interrupt
// RL10 - external offset maps offset input to zero
// RL11 - external gain maps span to full scale
// RL12 - external run corrects one channel only
// RL13 - every external run raises done interrupt
// RL14 - software applies reference before start
// RL15 - software recalibrates after settings change
// RL16 - software may restore saved correction values
// RL17 - several conversions combined per correction
// RL18 - power-on settling delays conversion start
// RL19 - low-power select chooses conversion mode
// RL20 - corrections stored, applied, kept until changed
package cal_pkg;
	localparam int NCH = 5;
	localparam logic [7:0] OFF_CAL_START = 8'h00;
	localparam logic [7:0] OFF_CAL_CTRL = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_CONFIG = 8'h0C;
	localparam logic [7:0] OFF_RESULT = 8'h10;
	localparam logic [7:0] OFF_AMP_BASE = 8'h20;
	localparam logic [7:0] OFF_OCV_BASE = 8'h40;
	localparam logic [7:0] OFF_GCV_BASE = 8'h60;
	localparam int AMP_SEL_BIT = 0;
	localparam int AMP_TGT_BIT = 1;
	localparam int AMP_GAIN_LSB = 2;
	localparam int AMP_OFS_LSB = 7;
	localparam int CFG_PON_BIT = 0;
	localparam int CFG_LPM_BIT = 1;
	localparam logic [1:0] MODE_INTERNAL = 2'h0;
	localparam logic [1:0] MODE_EXT_OFFSET = 2'h1;
	localparam logic [1:0] MODE_EXT_GAIN = 2'h2;
	localparam logic [23:0] FULL_SCALE = 24'h7FFFFF;
	localparam logic [23:0] GAIN_UNITY = 24'h400000;
	localparam int AVG_LOG2 = 3;
	localparam int CLK_MHZ = 40;
	localparam int SETTLE_US = 20;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	typedef enum logic [2:0] {ST_IDLE, ST_WAIT_CONV, ST_ACCUM, ST_STORE, ST_NEXT} cal_state_e;
endpackage : cal_pkg

// ### shared/conv_if.sv
/*
 * Carrier between controller and its correction unit.
 * Assumes one clock domain.
 */
`timescale 1ns/1ps
interface conv_if;
	logic [23:0] raw;
	logic [23:0] ofs;
	logic [23:0] gain;
	logic [23:0] corrected;
	modport ctrl (output raw, output ofs, output gain, input corrected);
	modport unit (input raw, input ofs, input gain, output corrected);
endinterface : conv_if

// ### rtl/cal_correct.sv
/*
 * Applies offset and gain correction to a raw result.
 * Assumes gain is fixed point with GAIN_UNITY as one.
 */
`timescale 1ns/1ps
module cal_correct (
	conv_if.unit cv
);
	logic signed [24:0] diff;
	logic signed [49:0] prod;
	always_comb begin
		diff = $signed({cv.raw[23], cv.raw}) - $signed({cv.ofs[23], cv.ofs});
		prod = diff * $signed({1'b0, cv.gain});
		cv.corrected = prod[45:22];
	end
endmodule : cal_correct

// ### rtl/settle_timer.sv
/*
 * Power-on settling timer; ready after the settle count.
 * Assumes power-on level from a register.
 */
`timescale 1ns/1ps
module settle_timer #(
	parameter int COUNT = cal_pkg::SETTLE_CYC
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic power_on,
	output logic ready
);
	logic [15:0] cnt;
	always_ff @(posedge clk) begin
		if (!resetn || !power_on) begin
			cnt <= 16'h0000;
			ready <= 1'b0;
		end else if (cnt == 16'(COUNT - 1)) begin
			ready <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
		end
	end
	AST_SETTLE: assert property (@(posedge clk) disable iff (!resetn)
		$rose(power_on) |-> !ready [*8]) else $error("ready too early"); // see RL18
endmodule : settle_timer

// ### rtl/sd_cal_ctrl.sv
/*
 * Calibration sequencer for a 24-bit sigma-delta converter with register port.
 * Assumes a modulator core delivering CONV_VALID pulses with CONV_DATA.
 */
`timescale 1ns/1ps
module sd_cal_ctrl #(
	parameter int SETTLE = cal_pkg::SETTLE_CYC
) (
	// clock and reset
	input wire logic CLK,
	input wire logic RESETN,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// converter core
	input wire logic CONV_VALID,
	input wire logic [23:0] CONV_DATA,
	input wire logic [2:0] CONV_CH,
	output logic CONV_START,
	output logic [2:0] CONV_SEL,
	output logic INT_REF_SEL,
	output logic LOW_POWER,
	// interrupt
	output logic CAL_DONE_IRQ
);
	localparam int N = cal_pkg::NCH;
	localparam int AVG = 1 << cal_pkg::AVG_LOG2;

	logic [11:0] channel_amp_config [N];
	logic [23:0] offset_correction_value [N];
	logic [23:0] gain_correction_value [N];
	logic [1:0] cal_mode_field;
	logic power_on;
	logic [2:0] result_channel_number;
	logic result_state_flag;
	logic [23:0] result_value;
	logic busy;
	logic conv_ready;
	cal_pkg::cal_state_e state;
	logic [2:0] ch;
	logic phase_gain;
	logic [3:0] nconv;
	logic signed [27:0] acc;
	logic [2:0] cur_ch;
	logic [23:0] cur_ofs;
	logic [23:0] cur_gain;

	conv_if cv ();
	cal_correct u_corr (.cv(cv));
	settle_timer #(.COUNT(SETTLE)) u_settle (
		.clk(CLK),
		.resetn(RESETN),
		.power_on(power_on),
		.ready(conv_ready)
	);

	function automatic logic eligible(input logic [11:0] cfg);
		eligible = !cfg[cal_pkg::AMP_SEL_BIT] && cfg[cal_pkg::AMP_TGT_BIT]; // see RL2 RL3
	endfunction : eligible

	function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input int i);
		hit = (a == base + 8'(4 * i));
	endfunction : hit

	// ------------------------------------------------
	// correction datapath
	// ------------------------------------------------
	always_comb begin
		cur_ofs = 24'h000000;
		cur_gain = cal_pkg::GAIN_UNITY;
		for (int i = 0; i < N; i++) begin
			if (CONV_CH == 3'(i)) begin
				cur_ofs = offset_correction_value[i];
				cur_gain = gain_correction_value[i];
			end
		end
		cv.raw = CONV_DATA;
		cv.ofs = cur_ofs;
		cv.gain = cur_gain;
	end

	// ------------------------------------------------
	// configuration registers
	// ------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			cal_mode_field <= cal_pkg::MODE_INTERNAL;
			power_on <= 1'b0;
			LOW_POWER <= 1'b0;
		end else if (WR) begin
			if (ADDR == cal_pkg::OFF_CAL_CTRL && !busy)
				cal_mode_field <= WDATA[1:0];
			if (ADDR == cal_pkg::OFF_CONFIG) begin
				power_on <= WDATA[cal_pkg::CFG_PON_BIT];
				LOW_POWER <= WDATA[cal_pkg::CFG_LPM_BIT]; // see RL19
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			for (int i = 0; i < N; i++)
				channel_amp_config[i] <= 12'h000;
		end else if (WR) begin
			for (int i = 0; i < N; i++)
				if (hit(ADDR, cal_pkg::OFF_AMP_BASE, i))
					channel_amp_config[i] <= WDATA[11:0];
		end
	end

	// ------------------------------------------------
	// sequencer
	// ------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			state <= cal_pkg::ST_IDLE;
			busy <= 1'b0;
			ch <= 3'h0;
			phase_gain <= 1'b0;
			nconv <= 4'h0;
			acc <= 28'h0000000;
			cur_ch <= 3'h0;
			CONV_START <= 1'b0;
			CONV_SEL <= 3'h0;
			INT_REF_SEL <= 1'b0;
			CAL_DONE_IRQ <= 1'b0;
			for (int i = 0; i < N; i++) begin
				offset_correction_value[i] <= 24'h000000;
				gain_correction_value[i] <= cal_pkg::GAIN_UNITY;
			end
		end else begin
			CONV_START <= 1'b0;
			CAL_DONE_IRQ <= 1'b0;
			case (state)
				cal_pkg::ST_IDLE: begin
					if (WR && ADDR == cal_pkg::OFF_CAL_START && WDATA[0]) begin // see RL1
						busy <= 1'b1;
						ch <= 3'h0;
						phase_gain <= 1'b0;
						state <= cal_pkg::ST_NEXT;
					end
					// restore of saved values by software, see RL16 RL20
					for (int i = 0; i < N; i++) begin
						if (WR && hit(ADDR, cal_pkg::OFF_OCV_BASE, i))
							offset_correction_value[i] <= WDATA[23:0];
						if (WR && hit(ADDR, cal_pkg::OFF_GCV_BASE, i))
							gain_correction_value[i] <= WDATA[23:0];
					end
				end
				cal_pkg::ST_NEXT: begin
					if (32'(ch) >= N) begin
						busy <= 1'b0;
						INT_REF_SEL <= 1'b0;
						CAL_DONE_IRQ <= 1'b1; // see RL9 RL13
						state <= cal_pkg::ST_IDLE;
					end else if (!eligible(channel_amp_config[ch])) begin
						ch <= ch + 3'h1;
					end else if (conv_ready) begin // see RL18
						cur_ch <= ch;
						CONV_SEL <= ch;
						INT_REF_SEL <= (cal_mode_field == cal_pkg::MODE_INTERNAL) && phase_gain;
						nconv <= 4'h0;
						acc <= 28'h0000000;
						CONV_START <= 1'b1;
						state <= cal_pkg::ST_ACCUM;
					end
				end
				cal_pkg::ST_ACCUM: begin
					if (CONV_VALID) begin // see RL17
						acc <= acc + 28'($signed(CONV_DATA));
						nconv <= nconv + 4'h1;
						if (32'(nconv) == AVG - 1)
							state <= cal_pkg::ST_STORE;
						else
							CONV_START <= 1'b1;
					end
				end
				cal_pkg::ST_STORE: begin
					state <= cal_pkg::ST_NEXT;
					if (!phase_gain && cal_mode_field != cal_pkg::MODE_EXT_GAIN) begin
						offset_correction_value[cur_ch] <= acc[26:3]; // see RL10
					end else begin
						gain_correction_value[cur_ch] <= gain_div(acc[26:3],
							offset_correction_value[cur_ch]); // see RL11
					end
					if (cal_mode_field == cal_pkg::MODE_INTERNAL && !phase_gain) begin
						phase_gain <= 1'b1; // see RL8
					end else if (cal_mode_field == cal_pkg::MODE_INTERNAL) begin
						phase_gain <= 1'b0;
						ch <= ch + 3'h1;
					end else begin
						ch <= 3'(N); // see RL12
					end
				end
				default: state <= cal_pkg::ST_IDLE;
			endcase
		end
	end

	function automatic logic [23:0] gain_div(input logic [23:0] meas, input logic [23:0] ofs);
		logic [47:0] num;
		logic [23:0] span;
		num = {24'h000000, cal_pkg::FULL_SCALE} << 22;
		span = meas - ofs;
		if (span == 24'h000000 || span[23])
			gain_div = cal_pkg::GAIN_UNITY;
		else
			gain_div = 24'(num / {24'h000000, span});
	endfunction : gain_div

	// ------------------------------------------------
	// conversion result
	// ------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			result_channel_number <= 3'h0;
			result_state_flag <= 1'b0;
			result_value <= 24'h000000;
		end else if (CONV_VALID && !busy) begin // see RL4
			result_channel_number <= CONV_CH;
			result_state_flag <= 1'b1;
			result_value <= cv.corrected; // see RL20
		end else if (RD && ADDR == cal_pkg::OFF_RESULT && !busy) begin
			result_state_flag <= 1'b0;
		end
	end

	// ------------------------------------------------
	// read port
	// ------------------------------------------------
	always_ff @(posedge CLK) begin
		if (!RESETN) begin
			RDATA <= 32'h00000000;
		end else if (RD) begin
			RDATA <= 32'h00000000;
			case (ADDR)
				cal_pkg::OFF_CAL_CTRL: RDATA <= {30'h00000000, cal_mode_field};
				cal_pkg::OFF_STATUS: RDATA <= {30'h00000000, conv_ready, busy};
				cal_pkg::OFF_CONFIG: RDATA <= {30'h00000000, LOW_POWER, power_on};
				cal_pkg::OFF_RESULT:
					RDATA <= {4'h0, result_state_flag, result_channel_number, result_value};
				default: begin
					for (int i = 0; i < N; i++) begin
						if (hit(ADDR, cal_pkg::OFF_AMP_BASE, i))
							RDATA <= {20'h00000, channel_amp_config[i]};
						if (hit(ADDR, cal_pkg::OFF_OCV_BASE, i))
							RDATA <= {8'h00, offset_correction_value[i]};
						if (hit(ADDR, cal_pkg::OFF_GCV_BASE, i))
							RDATA <= {8'h00, gain_correction_value[i]};
					end
				end
			endcase
		end
	end

	// ------------------------------------------------
	// checks
	// ------------------------------------------------
	AST_START: assert property (@(posedge CLK) disable iff (!RESETN)
		(state == cal_pkg::ST_IDLE && WR && ADDR == cal_pkg::OFF_CAL_START && WDATA[0])
		|=> busy) else $error("start ignored"); // see RL1
	AST_FROZEN: assert property (@(posedge CLK) disable iff (!RESETN)
		busy |=> $stable(result_value) && $stable(result_channel_number))
		else $error("result changed in calibration"); // see RL4
	AST_ELIG: assert property (@(posedge CLK) disable iff (!RESETN)
		(busy && CONV_START) |-> eligible(channel_amp_config[CONV_SEL]))
		else $error("ineligible channel converted"); // see RL2
	AST_SE: assert property (@(posedge CLK) disable iff (!RESETN)
		CONV_START && busy |-> !channel_amp_config[CONV_SEL][cal_pkg::AMP_SEL_BIT])
		else $error("single-ended calibrated"); // see RL3
	AST_DONE: assert property (@(posedge CLK) disable iff (!RESETN)
		$fell(busy) |-> CAL_DONE_IRQ) else $error("no done pulse"); // see RL9
	AST_DONE_EXT: assert property (@(posedge CLK) disable iff (!RESETN)
		CAL_DONE_IRQ |-> $past(state) == cal_pkg::ST_NEXT && !busy)
		else $error("stray done pulse"); // see RL13
	AST_MULTI: assert property (@(posedge CLK) disable iff (!RESETN)
		(state == cal_pkg::ST_STORE) |-> nconv == 4'(AVG))
		else $error("too few conversions"); // see RL17
	AST_ONECH: assert property (@(posedge CLK) disable iff (!RESETN)
		(state == cal_pkg::ST_STORE && cal_mode_field != cal_pkg::MODE_INTERNAL)
		|=> ch == 3'(N)) else $error("external touched two channels"); // see RL12
	AST_PWR: assert property (@(posedge CLK) disable iff (!RESETN)
		(busy && CONV_START) |-> conv_ready) else $error("start before settling"); // see RL18
endmodule : sd_cal_ctrl

// ### tb/conv_core_model.sv
/* Converter core model: one result per request, or one result per shot pulse.
   Assumes requests come one at a time. */
`timescale 1ns/1ps
module conv_core_model (
	// clock
	input wire logic clk,
	// requests
	input wire logic conv_start,
	input wire logic [2:0] conv_sel,
	input wire logic int_ref,
	input wire logic shot,
	input wire logic [2:0] shot_ch,
	// levels
	input wire logic [23:0] lvl,
	input wire logic [23:0] gref,
	input wire logic slow,
	// results
	output logic valid,
	output logic [23:0] data,
	output logic [2:0] ch
);
	logic [3:0] cnt;
	logic [2:0] idx;
	logic [2:0] sel_q;
	logic ref_q;
	logic shot_q;
	initial begin
		{valid, data, ch, cnt, idx, sel_q, ref_q, shot_q} = '0;
	end
	// single scan: one result per request, spread by idx
	always @(posedge clk) begin
		valid <= 1'b0;
		if (cnt == 4'h1) begin
			valid <= 1'b1;
			ch <= sel_q;
			data <= shot_q ? lvl : (ref_q ? gref : lvl) + {13'h0, sel_q, 8'h00} + {21'h0, idx};
			if (!shot_q) idx <= idx + 3'h1;
		end else if (valid) begin
			data <= ~data;
		end
		if (cnt != 4'h0) cnt <= cnt - 4'h1;
		else if (conv_start || shot) begin
			cnt <= slow ? 4'h6 : 4'h1;
			sel_q <= shot ? shot_ch : conv_sel;
			ref_q <= int_ref;
			shot_q <= shot;
		end
	end
endmodule : conv_core_model

// ### tb/sigma_delta_calibration_ctrl_bench.sv
/* Bench for the calibration sequencer with a reference model.
   Assumes the converter core model and the package. */
`timescale 1ns/1ps
module sigma_delta_calibration_ctrl_bench;
	logic CLK, RESETN, WR, RD, CONV_VALID, CONV_START, INT_REF_SEL, LOW_POWER, CAL_DONE_IRQ;
	logic [7:0] ADDR;
	logic [31:0] WDATA, RDATA, last_res;
	logic [23:0] CONV_DATA, lvl, gref;
	logic [2:0] CONV_CH, CONV_SEL, shot_ch;
	logic shot, slow;
	int bad_count = 0;
	int n_tests = 0;
	int n_start = 0;
	int n_irq = 0;
	integer seed = 32'h17f8;
	longint ofs_m [5];
	longint gain_m [5];
	longint rv, gv;
	// ----
	// clock, design, core
	// ----
	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	sd_cal_ctrl #(.SETTLE(8)) u_dut (.CLK(CLK), .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA),
		.WR(WR), .RD(RD), .RDATA(RDATA), .CONV_VALID(CONV_VALID), .CONV_DATA(CONV_DATA),
		.CONV_CH(CONV_CH), .CONV_START(CONV_START), .CONV_SEL(CONV_SEL),
		.INT_REF_SEL(INT_REF_SEL), .LOW_POWER(LOW_POWER), .CAL_DONE_IRQ(CAL_DONE_IRQ));
	conv_core_model u_core (.clk(CLK), .conv_start(CONV_START), .conv_sel(CONV_SEL),
		.int_ref(INT_REF_SEL), .shot(shot), .shot_ch(shot_ch), .lvl(lvl), .gref(gref),
		.slow(slow), .valid(CONV_VALID), .data(CONV_DATA), .ch(CONV_CH));
	always @(posedge CLK) begin
		if (CONV_START === 1'b1) n_start++;
		if (CAL_DONE_IRQ === 1'b1) n_irq++;
	end
	// ----
	// tasks
	// ----
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : end_sim
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= v;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask : wr
	task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		#1 chk(what, exp, RDATA);
	endtask : rchk
	function automatic longint gcal(input longint avg, input longint o);
		return (longint'(8388607) * 4194304) / (avg - o);
	endfunction : gcal
	task automatic chk_corr();
		for (int n = 0; n < 5; n++) begin
			rchk("offset", cal_pkg::OFF_OCV_BASE + 8'(4 * n), 32'(ofs_m[n]));
			rchk("gain", cal_pkg::OFF_GCV_BASE + 8'(4 * n), 32'(gain_m[n]));
		end
	endtask : chk_corr
	task automatic conv(input logic [2:0] c, input logic [23:0] raw);
		longint v;
		v = ((longint'(raw) - ofs_m[c]) * gain_m[c]) >>> 22;
		@(posedge CLK);
		lvl <= raw;
		shot <= 1'b1;
		shot_ch <= c;
		@(posedge CLK);
		shot <= 1'b0;
		repeat (8) @(posedge CLK);
		last_res = {4'h0, 1'b0, c, v[23:0]};
		rchk("result", cal_pkg::OFF_RESULT, last_res | 32'h08000000);
		rchk("flag", cal_pkg::OFF_RESULT, last_res);
	endtask : conv
	task automatic run_cal(input logic [1:0] mode, input int starts);
		int t;
		int s0;
		int i0;
		t = 0;
		s0 = n_start;
		i0 = n_irq;
		wr(cal_pkg::OFF_CAL_CTRL, {30'h0, mode});
		wr(cal_pkg::OFF_CAL_START, 32'h1);
		wr(cal_pkg::OFF_CAL_START, 32'h1);
		wr(cal_pkg::OFF_CAL_CTRL, 32'h3);
		wr(cal_pkg::OFF_OCV_BASE + 8'h08, 32'h5);
		rchk("busy", cal_pkg::OFF_STATUS, 32'h3);
		while (n_irq == i0 && t < 5000) begin
			@(posedge CLK);
			t++;
		end
		repeat (2) @(posedge CLK);
		chk("irq", 32'(i0 + 1), 32'(n_irq));
		chk("starts", 32'(s0 + starts), 32'(n_start));
		rchk("mode", cal_pkg::OFF_CAL_CTRL, {30'h0, mode});
		rchk("idle", cal_pkg::OFF_STATUS, 32'h2);
		rchk("frozen", cal_pkg::OFF_RESULT, last_res);
	endtask : run_cal
	// ----
	// main sequence
	// ----
	initial begin
		{ADDR, WDATA, WR, RD, shot, shot_ch, slow, lvl, gref, RESETN} = '0;
		for (int n = 0; n < 5; n++) begin
			ofs_m[n] = 0;
			gain_m[n] = 24'h400000;
		end
		repeat (12) @(posedge CLK);
		RESETN <= 1'b1;
		chk_corr();
		rchk("unmapped", 8'hFC, 32'h0);
		wr(cal_pkg::OFF_CONFIG, 32'h3);
		#1 chk("lowpower", 32'h1, {31'h0, LOW_POWER});
		rchk("settling", cal_pkg::OFF_STATUS, 32'h0);
		repeat (12) @(posedge CLK);
		rchk("ready", cal_pkg::OFF_STATUS, 32'h2);
		wr(cal_pkg::OFF_CONFIG, 32'h1);
		#1 chk("normal", 32'h0, {31'h0, LOW_POWER});
		conv(3'h2, 24'($random(seed)) & 24'h3FFFFF);
		for (int n = 0; n < 5; n++)
			wr(cal_pkg::OFF_AMP_BASE + 8'(4 * n), {25'h0, 5'($random(seed)), n != 2, n == 1});
		rv = $random(seed) & 32'hFFF;
		gv = 32'h500000 | ($random(seed) & 32'hFFFF);
		lvl <= 24'(rv);
		gref <= 24'(gv);
		for (int n = 0; n < 5; n++) begin
			if (n == 0 || n > 2) begin
				ofs_m[n] = rv + 256 * n + 3;
				gain_m[n] = gcal(gv + 256 * n + 3, ofs_m[n]);
			end
		end
		run_cal(cal_pkg::MODE_INTERNAL, 48);
		chk_corr();
		for (int n = 0; n < 4; n++) wr(cal_pkg::OFF_AMP_BASE + 8'(4 * n), 32'h0);
		slow <= 1'b1;
		rv = $random(seed) & 32'hFFF;
		lvl <= 24'(rv);
		ofs_m[4] = rv + 1027;
		run_cal(cal_pkg::MODE_EXT_OFFSET, 8);
		rv = 32'h300000 | ($random(seed) & 32'hFFFF);
		lvl <= 24'(rv);
		gain_m[4] = gcal(rv + 1027, ofs_m[4]);
		run_cal(cal_pkg::MODE_EXT_GAIN, 8);
		chk_corr();
		slow <= 1'b0;
		conv(3'h4, 24'(rv));
		wr(cal_pkg::OFF_OCV_BASE, 32'h123);
		wr(cal_pkg::OFF_GCV_BASE, 32'h3A0000);
		ofs_m[0] = 32'h123;
		gain_m[0] = 32'h3A0000;
		chk_corr();
		conv(3'h0, 24'h2345);
		end_sim();
	end
	initial begin
		repeat (20000) @(posedge CLK);
		bad_count++;
		end_sim();
	end
endmodule : sigma_delta_calibration_ctrl_bench
